// ===== hw/pda_defines.vh
// shared constants of the predistortion actuator
`ifndef PDA_DEFINES_VH
`define PDA_DEFINES_VH

`define PDA_DW          16
`define PDA_SMP_W       32
`define PDA_TAPS        4
`define PDA_TAPW        2
`define PDA_ORDERS      8
`define PDA_ORDW        3
`define PDA_ORD_TOP     3'h7
`define PDA_AMPW        4
`define PDA_IDX_TOP     4'hF
`define PDA_DLY         8
`define PDA_DLYW        3
`define PDA_REGIONS     8
`define PDA_CFG_REGIONS 7
`define PDA_REGW        3
`define PDA_REG_DEFAULT 3'h7
`define PDA_FREQW       32
`define PDA_LUT_AW      8
`define PDA_LUT_WW      128
`define PDA_COEF_AW     3
`define PDA_GAIN_FRAC   13
`define PDA_AMP_FRAC    15
`define PDA_AMP_FULL    17'h08000
`define PDA_BANK_RST    8'h00
`define PDA_CLK_MHZ     100
`define PDA_UPD_PERIOD_US 10000
`define PDA_UPD_CYCLES  (`PDA_UPD_PERIOD_US * `PDA_CLK_MHZ)

`endif

// ===== hw/pda_mem.v
// simple dual-port memory with registered read data
`default_nettype none

module pda_mem #(
  parameter AW = 8,
  parameter W  = 128
) (
  input  wire          clk,
  input  wire          we,
  input  wire [AW-1:0] waddr,
  input  wire [W-1:0]  wdata,
  input  wire [AW-1:0] raddr,
  output reg  [W-1:0]  rdata
);

  reg [W-1:0] mem [0:(1<<AW)-1];

  always @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule

`default_nettype wire

// ===== hw/pda_skid.v
// two-entry output buffer with valid/ready on both sides
`default_nettype none

module pda_skid #(
  parameter W = 32
) (
  input  wire         clk,
  input  wire         reset_n,
  input  wire         in_valid,
  output wire         in_ready,
  input  wire [W-1:0] in_data,
  output wire         out_valid,
  input  wire         out_ready,
  output wire [W-1:0] out_data
);

  reg [W-1:0] slot_r [0:1];
  reg         wptr_r;
  reg         rptr_r;
  reg [1:0]   cnt_r;

  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;

  assign in_ready  = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign out_data  = slot_r[rptr_r];

  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      wptr_r    <= 1'b0;
      rptr_r    <= 1'b0;
      cnt_r     <= 2'h0;
      slot_r[0] <= {W{1'b0}};
      slot_r[1] <= {W{1'b0}};
    end
    else
    begin
      if (push)
      begin
        slot_r[wptr_r] <= in_data;
        wptr_r         <= ~wptr_r;
      end
      if (pop)
      begin
        rptr_r <= ~rptr_r;
      end
      if (push && !pop)
      begin
        cnt_r <= cnt_r + 2'h1;
      end
      else if (pop && !push)
      begin
        cnt_r <= cnt_r - 2'h1;
      end
    end
  end

endmodule

`default_nettype wire

// ===== hw/pda_actuator.v
// predistortion actuator: amplitude lookup, delayed-tap products, ping-pong tables
`include "pda_defines.vh"
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Function
// R1: two tables per solution without hopping
// R2: background rebuild, swap without stopping transmit
// R3: sample amplitude indexes the active table
// R4: table outputs times delayed data, summed
// R5: tables hold precomputed per-tap polynomial sums
// R6: periodic update request, load via background path
// R7: engine captures predistorted and feedback samples
// R8: feedback loopback present before enabling
// R9: at most eight frequency regions
// R10: seven regions, lower bound included, upper excluded
// R11: unmatched frequency goes to eighth region
// R12: one solution per region for all hops
// R13: baseband applies crest factor reduction beforehand
// R14: polynomial orders zero through seven only
// R15: per-term inclusion bit, zero removes term
// R16: table swap only on sample boundaries
module pda_actuator #(
  parameter [31:0] UPD_CYCLES = `PDA_UPD_CYCLES
) (
  input  wire                                   clk,
  input  wire                                   reset_n,
  input  wire                                   dpd_enable,
  input  wire                                   fh_enable,
  input  wire [`PDA_FREQW-1:0]                  lo_freq,
  input  wire [`PDA_CFG_REGIONS*`PDA_FREQW-1:0] region_lower,
  input  wire [`PDA_CFG_REGIONS*`PDA_FREQW-1:0] region_upper,
  input  wire [`PDA_TAPS*`PDA_DLYW-1:0]         amp_delay,
  input  wire [`PDA_TAPS*`PDA_DLYW-1:0]         data_delay,
  input  wire [`PDA_TAPS*`PDA_ORDERS-1:0]       term_enable,
  input  wire                                   in_valid,
  output wire                                   in_ready,
  input  wire signed [`PDA_DW-1:0]              in_i,
  input  wire signed [`PDA_DW-1:0]              in_q,
  output wire                                   out_valid,
  input  wire                                   out_ready,
  output wire [`PDA_DW-1:0]                     out_i,
  output wire [`PDA_DW-1:0]                     out_q,
  input  wire                                   fb_valid,
  input  wire [`PDA_DW-1:0]                     fb_i,
  input  wire [`PDA_DW-1:0]                     fb_q,
  output reg                                    cap_valid,
  output reg  [`PDA_DW-1:0]                     cap_x_i,
  output reg  [`PDA_DW-1:0]                     cap_x_q,
  output reg  [`PDA_DW-1:0]                     cap_y_i,
  output reg  [`PDA_DW-1:0]                     cap_y_q,
  output reg                                    upd_req,
  input  wire                                   coef_wr,
  output wire                                   coef_wr_ready,
  input  wire [`PDA_COEF_AW-1:0]                coef_order,
  input  wire [`PDA_LUT_WW-1:0]                 coef_data,
  input  wire [`PDA_REGW-1:0]                   coef_region,
  input  wire                                   coef_commit,
  output wire                                   build_busy,
  output wire [`PDA_REGIONS-1:0]                active_bank
);

  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_RD   = 2'h1;
  localparam [1:0] S_MAC  = 2'h2;
  localparam [1:0] S_OUT  = 2'h3;
  localparam [1:0] B_IDLE = 2'h0;
  localparam [1:0] B_RD   = 2'h1;
  localparam [1:0] B_AC   = 2'h2;
  localparam [1:0] B_WR   = 2'h3;

  //////////////////////////////////////////////////////////////////////////////
  // functions

  function signed [31:0] mul16;
    input signed [15:0] a;
    input signed [15:0] b;
    begin
      mul16 = a * b;
    end
  endfunction

  function [15:0] sat16;
    input signed [21:0] v;
    begin
      if (v > 22'sh007FFF)
        sat16 = 16'h7FFF;
      else if (v < -22'sh008000)
        sat16 = 16'h8000;
      else
        sat16 = v[15:0];
    end
  endfunction

  function [2:0] sel3;
    input [11:0] v;
    input [1:0]  t;
    begin
      case (t)
        2'h0:    sel3 = v[2:0];
        2'h1:    sel3 = v[5:3];
        2'h2:    sel3 = v[8:6];
        default: sel3 = v[11:9];
      endcase
    end
  endfunction

  // max + min/2 magnitude estimate, clipped to the top table entry
  function [3:0] amp_index;
    input signed [15:0] i;
    input signed [15:0] q;
    reg [16:0] ai;
    reg [16:0] aq;
    reg [16:0] amp;
    begin
      ai  = i[15] ? (17'h0 - {i[15], i}) : {1'b0, i};
      aq  = q[15] ? (17'h0 - {q[15], q}) : {1'b0, q};
      amp = (ai > aq) ? (ai + {1'b0, aq[16:1]}) : (aq + {1'b0, ai[16:1]});
      if (amp >= `PDA_AMP_FULL)
        amp_index = `PDA_IDX_TOP;
      else
        amp_index = amp[14:11];
    end
  endfunction

  // one horner step: acc*A + term, A unsigned Q1.15
  function [15:0] horner;
    input signed [15:0] acc;
    input [15:0]        a;
    input signed [15:0] term;
    reg signed [32:0] p;
    reg signed [32:0] s;
    begin
      p = acc * $signed({1'b0, a});
      s = (p >>> `PDA_AMP_FRAC) + term;
      horner = sat16(s[21:0]);
    end
  endfunction

  function [2:0] region_of;
    input [`PDA_FREQW-1:0]                  f;
    input [`PDA_CFG_REGIONS*`PDA_FREQW-1:0] lo;
    input [`PDA_CFG_REGIONS*`PDA_FREQW-1:0] hi;
    integer r;
    begin
      region_of = `PDA_REG_DEFAULT; // R11
      for (r = `PDA_CFG_REGIONS - 1; r >= 0; r = r - 1)
        if (f >= lo[r*`PDA_FREQW +: `PDA_FREQW] && f < hi[r*`PDA_FREQW +: `PDA_FREQW]) // R10
          region_of = r[2:0];
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // state

  reg [1:0]                 st_r;
  reg [`PDA_TAPW-1:0]       tap_r;
  reg signed [`PDA_DW-1:0]  dl_i_r [0:`PDA_DLY-1];
  reg signed [`PDA_DW-1:0]  dl_q_r [0:`PDA_DLY-1];
  reg [`PDA_AMPW-1:0]       dl_a_r [0:`PDA_DLY-1];
  reg [`PDA_REGW-1:0]       sreg_r;
  reg                       sbank_r;
  reg signed [21:0]         acc_i_r;
  reg signed [21:0]         acc_q_r;
  reg [`PDA_DW-1:0]         ox_i_r;
  reg [`PDA_DW-1:0]         ox_q_r;
  reg [`PDA_DW-1:0]         last_i_r;
  reg [`PDA_DW-1:0]         last_q_r;
  reg [1:0]                 bst_r;
  reg [`PDA_REGW-1:0]       breg_r;
  reg [`PDA_AMPW-1:0]       bidx_r;
  reg [`PDA_ORDW-1:0]       bord_r;
  reg [15:0]                bacc_i_r [0:`PDA_TAPS-1];
  reg [15:0]                bacc_q_r [0:`PDA_TAPS-1];
  reg [`PDA_REGIONS-1:0]    bank_r;
  reg [31:0]                upd_cnt_r;
  integer                   j;

  wire [`PDA_LUT_WW-1:0]    lut_rdata;
  wire [`PDA_LUT_WW-1:0]    coef_rdata;
  wire [`PDA_LUT_WW-1:0]    lut_wdata;
  wire                      skid_ready;
  wire [`PDA_SMP_W-1:0]     skid_out;

  wire accept = in_valid && (st_r == S_IDLE);
  wire [`PDA_REGW-1:0] cur_region = fh_enable ? region_of(lo_freq, region_lower, region_upper) : 3'h0; // R1 R9 R12

  assign in_ready      = (st_r == S_IDLE);
  assign coef_wr_ready = (bst_r == B_IDLE);
  assign build_busy    = (bst_r != B_IDLE);
  assign active_bank   = bank_r;

  //////////////////////////////////////////////////////////////////////////////
  // sample path

  wire [2:0]  kd   = sel3(data_delay, tap_r);
  wire [2:0]  ld   = sel3(amp_delay, tap_r);
  wire [31:0] gain = lut_rdata[{tap_r, 5'h00} +: 32];
  wire signed [15:0] g_i = gain[31:16];
  wire signed [15:0] g_q = gain[15:0];
  wire signed [31:0] p_ii = mul16(g_i, dl_i_r[kd]);
  wire signed [31:0] p_qq = mul16(g_q, dl_q_r[kd]);
  wire signed [31:0] p_iq = mul16(g_i, dl_q_r[kd]);
  wire signed [31:0] p_qi = mul16(g_q, dl_i_r[kd]);
  wire signed [32:0] m_re = ($signed({p_ii[31], p_ii}) - $signed({p_qq[31], p_qq})) >>> `PDA_GAIN_FRAC;
  wire signed [32:0] m_im = ($signed({p_iq[31], p_iq}) + $signed({p_qi[31], p_qi})) >>> `PDA_GAIN_FRAC;
  wire signed [21:0] sum_i = acc_i_r + m_re[21:0]; // R4
  wire signed [21:0] sum_q = acc_q_r + m_im[21:0];

  wire [`PDA_LUT_AW-1:0] lut_raddr = {sreg_r, sbank_r, dl_a_r[ld]}; // R3

  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      st_r    <= S_IDLE;
      tap_r   <= 2'h0;
      sreg_r  <= 3'h0;
      sbank_r <= 1'b0;
      acc_i_r <= 22'h0;
      acc_q_r <= 22'h0;
      ox_i_r  <= 16'h0;
      ox_q_r  <= 16'h0;
      for (j = 0; j < `PDA_DLY; j = j + 1)
      begin
        dl_i_r[j] <= 16'h0;
        dl_q_r[j] <= 16'h0;
        dl_a_r[j] <= 4'h0;
      end
    end
    else
    begin
      case (st_r)
        S_IDLE:
        begin
          if (accept)
          begin
            for (j = `PDA_DLY - 1; j > 0; j = j - 1)
            begin
              dl_i_r[j] <= dl_i_r[j-1];
              dl_q_r[j] <= dl_q_r[j-1];
              dl_a_r[j] <= dl_a_r[j-1];
            end
            dl_i_r[0] <= in_i;
            dl_q_r[0] <= in_q;
            dl_a_r[0] <= amp_index(in_i, in_q); // R3
            sreg_r    <= cur_region;
            sbank_r   <= bank_r[cur_region]; // R16
            tap_r     <= 2'h0;
            acc_i_r   <= 22'h0;
            acc_q_r   <= 22'h0;
            // bypass until the loopback is known to be in place
            if (dpd_enable) // R8
            begin
              st_r <= S_RD;
            end
            else
            begin
              ox_i_r <= in_i;
              ox_q_r <= in_q;
              st_r   <= S_OUT;
            end
          end
        end
        S_RD:
        begin
          st_r <= S_MAC;
        end
        S_MAC:
        begin
          acc_i_r <= sum_i;
          acc_q_r <= sum_q;
          if (tap_r == 2'h3)
          begin
            ox_i_r <= sat16(sum_i); // R4
            ox_q_r <= sat16(sum_q);
            st_r   <= S_OUT;
          end
          else
          begin
            tap_r <= tap_r + 2'h1;
            st_r  <= S_RD;
          end
        end
        S_OUT:
        begin
          if (skid_ready)
          begin
            st_r <= S_IDLE;
          end
        end
        default:
        begin
          st_r <= S_IDLE;
        end
      endcase
    end
  end

  pda_skid #(
    .W (`PDA_SMP_W)
  ) u_skid (
    .clk       (clk),
    .reset_n   (reset_n),
    .in_valid  (st_r == S_OUT),
    .in_ready  (skid_ready),
    .in_data   ({ox_i_r, ox_q_r}),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (skid_out)
  );

  assign out_i = skid_out[31:16];
  assign out_q = skid_out[15:0];

  //////////////////////////////////////////////////////////////////////////////
  // coefficient capture and update request

  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      last_i_r  <= 16'h0;
      last_q_r  <= 16'h0;
      cap_valid <= 1'b0;
      cap_x_i   <= 16'h0;
      cap_x_q   <= 16'h0;
      cap_y_i   <= 16'h0;
      cap_y_q   <= 16'h0;
      upd_req   <= 1'b0;
      upd_cnt_r <= 32'h0;
    end
    else
    begin
      if (st_r == S_OUT && skid_ready)
      begin
        last_i_r <= ox_i_r;
        last_q_r <= ox_q_r;
      end
      cap_valid <= fb_valid && dpd_enable; // R7
      if (fb_valid)
      begin
        cap_x_i <= last_i_r;
        cap_x_q <= last_q_r;
        cap_y_i <= fb_i;
        cap_y_q <= fb_q;
      end
      // period restarts whenever predistortion is switched off
      upd_req <= 1'b0;
      if (!dpd_enable)
      begin
        upd_cnt_r <= 32'h0;
      end
      else if (upd_cnt_r >= UPD_CYCLES - 32'h1)
      begin
        upd_cnt_r <= 32'h0;
        upd_req   <= 1'b1; // R6
      end
      else
      begin
        upd_cnt_r <= upd_cnt_r + 32'h1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // background table builder

  wire [15:0] b_amp = {1'b0, bidx_r, 11'h400};

  genvar g;
  generate
    for (g = 0; g < `PDA_TAPS; g = g + 1)
    begin : g_pack
      assign lut_wdata[g*32 +: 32] = {bacc_i_r[g], bacc_q_r[g]};
    end
  endgenerate

  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      bst_r  <= B_IDLE;
      breg_r <= 3'h0;
      bidx_r <= 4'h0;
      bord_r <= `PDA_ORD_TOP;
      bank_r <= `PDA_BANK_RST;
      for (j = 0; j < `PDA_TAPS; j = j + 1)
      begin
        bacc_i_r[j] <= 16'h0;
        bacc_q_r[j] <= 16'h0;
      end
    end
    else
    begin
      case (bst_r)
        B_IDLE:
        begin
          if (coef_commit)
          begin
            breg_r <= coef_region; // R12
            bidx_r <= 4'h0;
            bord_r <= `PDA_ORD_TOP; // R14
            bst_r  <= B_RD;
          end
        end
        B_RD:
        begin
          bst_r <= B_AC;
        end
        B_AC:
        begin
          for (j = 0; j < `PDA_TAPS; j = j + 1)
          begin
            bacc_i_r[j] <= horner(bacc_i_r[j], b_amp,
              term_enable[j*`PDA_ORDERS + bord_r] ? coef_rdata[j*32+16 +: 16] : 16'h0); // R5 R15
            bacc_q_r[j] <= horner(bacc_q_r[j], b_amp,
              term_enable[j*`PDA_ORDERS + bord_r] ? coef_rdata[j*32 +: 16] : 16'h0);
          end
          if (bord_r == 3'h0)
          begin
            bst_r <= B_WR;
          end
          else
          begin
            bord_r <= bord_r - 3'h1;
            bst_r  <= B_RD;
          end
        end
        B_WR:
        begin
          for (j = 0; j < `PDA_TAPS; j = j + 1)
          begin
            bacc_i_r[j] <= 16'h0;
            bacc_q_r[j] <= 16'h0;
          end
          bord_r <= `PDA_ORD_TOP;
          if (bidx_r == `PDA_IDX_TOP)
          begin
            bank_r[breg_r] <= ~bank_r[breg_r]; // R2
            bst_r          <= B_IDLE;
          end
          else
          begin
            bidx_r <= bidx_r + 4'h1;
            bst_r  <= B_RD;
          end
        end
        default:
        begin
          bst_r <= B_IDLE;
        end
      endcase
    end
  end

  // coefficients may only be rewritten while no build reads them
  pda_mem #(
    .AW (`PDA_COEF_AW),
    .W  (`PDA_LUT_WW)
  ) u_coef (
    .clk   (clk),
    .we    (coef_wr && coef_wr_ready),
    .waddr (coef_order),
    .wdata (coef_data),
    .raddr (bord_r),
    .rdata (coef_rdata)
  );

  // the build always writes the bank that is not live
  pda_mem #(
    .AW (`PDA_LUT_AW),
    .W  (`PDA_LUT_WW)
  ) u_lut (
    .clk   (clk),
    .we    (bst_r == B_WR),
    .waddr ({breg_r, ~bank_r[breg_r], bidx_r}), // R1 R2
    .wdata (lut_wdata),
    .raddr (lut_raddr),
    .rdata (lut_rdata)
  );

endmodule

`default_nettype wire

// ===== bench/pda_act_checker.sv
// port-level assertions for the predistortion actuator
`include "pda_defines.vh"
`default_nettype none
module pda_act_checker #(
  parameter [31:0] UPD_CYCLES = 32'h32
) (
  input wire logic                 clk,
  input wire logic                 reset_n,
  input wire logic                 dpd_enable,
  input wire logic                 in_valid,
  input wire logic                 in_ready,
  input wire logic                 out_valid,
  input wire logic                 out_ready,
  input wire logic [`PDA_DW-1:0]   out_i,
  input wire logic [`PDA_DW-1:0]   out_q,
  input wire logic                 fb_valid,
  input wire logic [`PDA_DW-1:0]   fb_i,
  input wire logic [`PDA_DW-1:0]   fb_q,
  input wire logic                 cap_valid,
  input wire logic [`PDA_DW-1:0]   cap_y_i,
  input wire logic [`PDA_DW-1:0]   cap_y_q,
  input wire logic                 upd_req,
  input wire logic                 coef_commit,
  input wire logic                 coef_wr_ready,
  input wire logic                 build_busy,
  input wire logic [`PDA_REGIONS-1:0] active_bank
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] gap_r;
  logic        armed_r;
  logic [9:0]  busy_r;
  // gap only judged once a first pulse has been seen with the timer running
  always @(posedge clk)
  begin
    if (!reset_n || !dpd_enable)
    begin
      gap_r   <= 32'h0;
      armed_r <= 1'b0;
    end
    else if (upd_req)
    begin
      gap_r   <= 32'h1;
      armed_r <= 1'b1;
    end
    else
      gap_r <= gap_r + 32'h1;
    busy_r <= (reset_n && build_busy) ? busy_r + 10'h1 : 10'h0;
  end
  ////////////////////////////////////////////////////////////
  chk_cap_follow: assert property (@(posedge clk) disable iff (!reset_n)
    cap_valid == $past(fb_valid && dpd_enable)) else $error("capture strobe off");
  chk_cap_data: assert property (@(posedge clk) disable iff (!reset_n)
    cap_valid |-> cap_y_i == $past(fb_i) && cap_y_q == $past(fb_q)) else $error("capture data off");
  chk_upd_gap: assert property (@(posedge clk) disable iff (!reset_n)
    upd_req && armed_r |-> gap_r == UPD_CYCLES) else $error("update spacing off");
  chk_upd_idle: assert property (@(posedge clk) disable iff (!reset_n)
    !dpd_enable && !$past(dpd_enable) |-> !upd_req) else $error("update while disabled");
  chk_build_len: assert property (@(posedge clk) disable iff (!reset_n)
    $fell(build_busy) |-> busy_r >= 10'h10F && busy_r <= 10'h111) else $error("build length off");
  chk_bank_swap: assert property (@(posedge clk) disable iff (!reset_n)
    $fell(build_busy) |-> $onehot(active_bank ^ $past(active_bank))) else $error("bank not swapped");
  chk_bank_still: assert property (@(posedge clk) disable iff (!reset_n)
    !$fell(build_busy) |-> $stable(active_bank)) else $error("bank moved mid build");
  chk_wr_ready: assert property (@(posedge clk) disable iff (!reset_n)
    coef_wr_ready == !build_busy) else $error("write ready off");
  chk_commit_busy: assert property (@(posedge clk) disable iff (!reset_n)
    coef_commit && coef_wr_ready |=> build_busy [*8]) else $error("commit not taken");
  chk_one_sample: assert property (@(posedge clk) disable iff (!reset_n)
    in_valid && in_ready |=> !in_ready) else $error("second sample taken");
  chk_out_hold: assert property (@(posedge clk) disable iff (!reset_n)
    out_valid && !out_ready |=> out_valid && $stable(out_i) && $stable(out_q)) else $error("output dropped");
endmodule
bind pda_actuator pda_act_checker #(.UPD_CYCLES(UPD_CYCLES)) u_chk (.clk, .reset_n, .dpd_enable,
  .in_valid, .in_ready, .out_valid, .out_ready, .out_i, .out_q, .fb_valid, .fb_i, .fb_q, .cap_valid,
  .cap_y_i, .cap_y_q, .upd_req, .coef_commit, .coef_wr_ready, .build_busy, .active_bank);
`default_nettype wire

// ===== bench/pda_bb_src.sv
// baseband sample source on the actuator input handshake
`default_nettype none
module pda_bb_src (
  input  wire logic        clk,
  input  wire logic        in_ready,
  output var  logic        in_valid,
  output var  logic [15:0] in_i,
  output var  logic [15:0] in_q
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] PEAK = 16'h6000;
  logic [31:0] q[$];
  logic [31:0] w;
  int          gap = 0;
  // hard clip stands in for crest factor reduction upstream
  function automatic logic [15:0] cfr(input logic [15:0] v);
    if ($signed(v) > $signed(PEAK))
      return PEAK;
    if ($signed(v) < -$signed(PEAK))
      return -PEAK;
    return v;
  endfunction
  ////////////////////////////////////////////////////////////
  initial
  begin
    in_valid = 1'b0;
    in_i = 16'h0;
    in_q = 16'h0;
    forever
    begin
      @(negedge clk);
      if (q.size() > 0)
      begin
        repeat (gap) @(negedge clk);
        w = q.pop_front();
        in_valid = 1'b1;
        in_i = cfr(w[31:16]);
        in_q = cfr(w[15:0]);
        while (in_ready !== 1'b1)
          @(negedge clk);
        @(negedge clk);
        in_valid = 1'b0;
        // released lines flip so a stale word never looks valid
        in_i = ~in_i;
        in_q = ~in_q;
      end
    end
  end
endmodule
`default_nettype wire

// ===== bench/tb_predistortion_actuator.sv
// self-checking testbench of the predistortion actuator
`include "pda_defines.vh"
`default_nettype none
module tb_predistortion_actuator;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] UPD = 32'h32;
  logic clk = 1'b0, reset_n = 1'b0, dpd_enable = 1'b0, fh_enable = 1'b0, out_ready = 1'b0;
  logic fb_valid = 1'b0, coef_wr = 1'b0, coef_commit = 1'b0;
  logic [`PDA_FREQW-1:0] lo_freq = '0;
  logic [`PDA_CFG_REGIONS*`PDA_FREQW-1:0] region_lower = '0, region_upper = '0;
  logic [`PDA_TAPS*`PDA_DLYW-1:0] amp_delay = '0, data_delay = '0;
  logic [`PDA_TAPS*`PDA_ORDERS-1:0] term_enable = '0;
  logic [`PDA_DW-1:0] fb_i = '0, fb_q = '0;
  logic [`PDA_COEF_AW-1:0] coef_order = '0;
  logic [`PDA_LUT_WW-1:0] coef_data = '0;
  logic [`PDA_REGW-1:0] coef_region = '0;
  wire in_valid, in_ready, out_valid, cap_valid, upd_req, coef_wr_ready, build_busy;
  wire [`PDA_DW-1:0] in_i, in_q, out_i, out_q, cap_x_i, cap_x_q, cap_y_i, cap_y_q;
  wire [`PDA_REGIONS-1:0] active_bank;
  int miscompares = 0;
  int tests_run = 0;
  logic [31:0] outq[$];
  pda_bb_src src (.clk(clk), .in_ready(in_ready), .in_valid(in_valid), .in_i(in_i), .in_q(in_q));
  pda_actuator #(.UPD_CYCLES(UPD)) dut (.clk, .reset_n, .dpd_enable, .fh_enable, .lo_freq, .region_lower,
    .region_upper, .amp_delay, .data_delay, .term_enable, .in_valid, .in_ready, .in_i, .in_q, .out_valid,
    .out_ready, .out_i, .out_q, .fb_valid, .fb_i, .fb_q, .cap_valid, .cap_x_i, .cap_x_q, .cap_y_i, .cap_y_q,
    .upd_req, .coef_wr, .coef_wr_ready, .coef_order, .coef_data, .coef_region, .coef_commit, .build_busy,
    .active_bank);
  always #5 clk = ~clk;
  // receiver side: a word counts when both flags stand before the rising edge
  always @(negedge clk)
  begin
    #1;
    if (out_valid === 1'b1 && out_ready === 1'b1)
      outq.push_back({out_i, out_q});
  end
  ////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic get_out(output logic [31:0] v);
    int n;
    n = 0;
    while (outq.size() == 0 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    if (outq.size() == 0)
    begin
      miscompares++;
      report_and_stop();
    end
    else
      v = outq.pop_front();
  endtask
  task automatic build(input logic [2:0] rg, input logic [15:0] gain, input logic [31:0] te);
    int n;
    logic [7:0] bank0;
    @(negedge clk);
    term_enable = te;
    coef_region = rg;
    bank0 = active_bank;
    for (int o = 0; o < 8; o++)
    begin
      coef_wr = 1'b1;
      coef_order = o[2:0];
      coef_data = {96'h0, gain, 16'h0};
      @(negedge clk);
    end
    coef_wr = 1'b0;
    coef_commit = 1'b1;
    @(negedge clk);
    coef_commit = 1'b0;
    check("busy", build_busy, 1'b1);
    n = 0;
    while (build_busy === 1'b1 && n < 400)
    begin
      @(negedge clk);
      n++;
    end
    if (build_busy !== 1'b0)
    begin
      miscompares++;
      report_and_stop();
    end
    else
      check("bank", active_bank, bank0 ^ (8'h01 << rg));
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_buffer;
    logic [31:0] v;
    for (int k = 0; k < 4; k++)
      src.q.push_back({16'h0100 + k[15:0], 16'h0F00 - k[15:0]});
    repeat (30) @(negedge clk);
    check("stall ready", in_ready, 1'b0);
    check("stall valid", out_valid, 1'b1);
    out_ready = 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      get_out(v);
      check("bypass word", v, {16'h0100 + k[15:0], 16'h0F00 - k[15:0]});
    end
  endtask
  task automatic t_tables;
    logic [31:0] v;
    build(3'h0, 16'h2000, 32'h1);
    src.q.push_back(32'h0400FC00);
    get_out(v);
    check("unit gain", v, 32'h0400FC00);
    build(3'h0, 16'h2000, 32'h0);
    check("ping pong", active_bank, 8'h00);
    src.q.push_back(32'h0400FC00);
    get_out(v);
    check("term dropped", v, 32'h0);
    build(3'h0, 16'h4000, 32'h2);
    src.q.push_back(32'h20000000);
    get_out(v);
    check("amp index", v, 32'h12000000);
    build(3'h0, 16'h2000, 32'h1);
  endtask
  task automatic t_delay;
    logic [31:0] v;
    src.gap = 5;
    data_delay = 12'h001;
    amp_delay = 12'h003;
    src.q.push_back(32'h0200FE00);
    src.q.push_back(32'h0300FD00);
    get_out(v);
    get_out(v);
    check("delayed tap", v, 32'h0200FE00);
    data_delay = 12'h000;
    amp_delay = 12'h000;
    src.gap = 0;
  endtask
  task automatic t_region;
    logic [31:0] v;
    logic [31:0] f [4] = '{32'h64, 32'hC7, 32'hC8, 32'h1388};
    build(3'h7, 16'h4000, 32'h1);
    fh_enable = 1'b1;
    region_lower[31:0] = 32'h64;
    region_upper[31:0] = 32'hC8;
    for (int k = 0; k < 4; k++)
    begin
      lo_freq = f[k];
      src.q.push_back(32'h0400FC00);
      get_out(v);
      check("region gain", v, (k < 2) ? 32'h0400FC00 : 32'h0800F800);
    end
    fh_enable = 1'b0;
    src.q.push_back(32'h0400FC00);
    get_out(v);
    check("no hop", v, 32'h0400FC00);
  endtask
  task automatic t_capture;
    @(negedge clk);
    fb_valid = 1'b1;
    fb_i = 16'h1234;
    fb_q = 16'h5678;
    @(negedge clk);
    fb_valid = 1'b0;
    fb_i = 16'hEDCB;
    fb_q = 16'hA987;
    check("cap strobe", cap_valid, 1'b1);
    check("cap fb", {cap_y_i, cap_y_q}, 32'h12345678);
    check("cap tx", {cap_x_i, cap_x_q}, 32'h0400FC00);
  endtask
  task automatic t_update;
    int n;
    n = 0;
    repeat (250)
    begin
      @(negedge clk);
      n += (upd_req === 1'b1);
    end
    check("update count", n, 5);
    dpd_enable = 1'b0;
    repeat (2) @(negedge clk);
    n = 0;
    repeat (100)
    begin
      @(negedge clk);
      n += (upd_req === 1'b1);
    end
    check("update off", n, 0);
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    repeat (5) @(negedge clk);
    reset_n = 1'b1;
    t_buffer();
    dpd_enable = 1'b1;
    t_tables();
    t_delay();
    t_region();
    t_capture();
    t_update();
    report_and_stop();
  end
endmodule
`default_nettype wire
